// ### verilog/buck_two_control_regs.sv
/*
  control register bank of the second buck converter, reached by the serial control front end.
  assumes the front end presents byte writes and reads as one-cycle strobes on clock_i,
  and that range configuration is loaded by the one-time-programmable / test configuration path.
*/
// Operation
// [R1] registers reached only via serial control port
// [R2] 0x35 bits 5:0 normal set point, RW
// [R3] normal range bit 6 read-only, from configuration
// [R4] 0x36 bits 5:0 standby set point, RW
// [R5] standby bit 6 copies configured range
// [R6] 0x37 bits 5:0 sleep set point, RW
// [R7] sleep bit 6 mirrors configured range
// [R8] 0x38 bits 3:0 switching mode, RW
// [R9] mode bit 5: sleep off or PFM
// [R10] 0x39 bit 0 current limit select
// [R11] config bits 3:2 switching frequency select
// [R12] config bits 5:4 phase clock select
// [R13] config bits 7:6 ramp speed select
// [R14] host uses codes 0..63 below 2.0 V
// [R15] unused bits read zero, ignore writes; config bit 1 is stored and reads back as written
`timescale 1ns/1ps
module buck_two_control_regs (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  // serial control register access
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_rvalid_o,
  // configuration load of the range bit
  input  wire logic       range_load_i,
  input  wire logic       range_value_i,
  // converter controls
  output logic      [6:0] normal_code_o,
  output logic      [6:0] standby_code_o,
  output logic      [6:0] sleep_code_o,
  output logic      [3:0] switching_mode_o,
  output logic            sleep_behaviour_bit_o,
  output logic            current_limit_select_o,
  output logic      [1:0] switching_frequency_select_o,
  output logic      [1:0] phase_clock_select_o,
  output logic      [1:0] voltage_ramp_speed_select_o
);
  logic        range_q;
  logic        rd_pend_q;
  logic        rd_hit_q;
  logic [7:0]  mem_rdata;
  logic [39:0] flat;
  logic [2:0]  idx;
  logic [2:0]  rd_idx;
  logic        hit;
  logic [7:0]  wmask;
  logic [7:0]  nrm;
  logic [7:0]  stb;
  logic [7:0]  slp;
  logic [7:0]  mde;
  logic [7:0]  cfg;
  logic [7:0]  rd_d;

  function automatic logic [7:0] mask_of(input logic [2:0] i);
    unique case (i)
      3'd0, 3'd1, 3'd2: mask_of = buck_regs_pkg::MASK_SETPT;
      3'd3:             mask_of = buck_regs_pkg::MASK_MODE;
      3'd4:             mask_of = buck_regs_pkg::MASK_CONFIG;
      default:          mask_of = 8'h00;
    endcase
  endfunction : mask_of

  // address decode
  assign idx   = 3'(reg_addr_i - buck_regs_pkg::OFF_FIRST);
  assign hit   = (reg_addr_i >= buck_regs_pkg::OFF_NORMAL) &&
                 (reg_addr_i <= buck_regs_pkg::OFF_CONFIG); // R1
  assign wmask = hit ? mask_of(idx) : 8'h00; // R15
  // unmapped reads point past the storage so they return zero
  assign rd_idx = hit ? idx : 3'd7; // R15

  buck_reg_mem #(
    .DEPTH (buck_regs_pkg::NUM_REGS)
  ) u_mem (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .wr_en_i   (reg_wr_i && hit),
    .wr_idx_i  (idx),
    .wr_data_i (reg_wdata_i),
    .wr_mask_i (wmask),
    .rd_idx_i  (rd_idx),
    .rd_data_o (mem_rdata),
    .flat_o    (flat)
  );

  assign nrm = flat[7:0];
  assign stb = flat[15:8];
  assign slp = flat[23:16];
  assign mde = flat[31:24];
  assign cfg = flat[39:32];

  // range bit loaded by configuration only
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      range_q <= 1'b0;
    end else if (range_load_i) begin
      range_q <= range_value_i; // R3
    end
  end

  // read path: bit 6 of set-point registers shows the range
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rd_pend_q <= 1'b0;
      rd_hit_q  <= 1'b0;
    end else begin
      rd_pend_q <= reg_rd_i;
      rd_hit_q  <= reg_rd_i && hit && (idx <= 3'd2);
    end
  end

  assign rd_d = rd_hit_q ? (mem_rdata | {1'b0, range_q, 6'h00}) : mem_rdata; // R5 R7

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= rd_pend_q;
      if (rd_pend_q) begin
        reg_rdata_o <= rd_d;
      end
    end
  end

  // converter control outputs, registered
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      normal_code_o                <= 7'h00;
      standby_code_o               <= 7'h00;
      sleep_code_o                 <= 7'h00;
      switching_mode_o             <= 4'h0;
      sleep_behaviour_bit_o        <= 1'b0;
      current_limit_select_o       <= 1'b0;
      switching_frequency_select_o <= 2'h0;
      phase_clock_select_o         <= 2'h0;
      voltage_ramp_speed_select_o  <= 2'h0;
    end else begin
      normal_code_o                <= {range_q, nrm[5:0]}; // R2
      standby_code_o               <= {range_q, stb[5:0]}; // R4
      sleep_code_o                 <= {range_q, slp[5:0]}; // R6
      switching_mode_o             <= mde[3:0]; // R8
      sleep_behaviour_bit_o        <= mde[5]; // R9
      current_limit_select_o       <= cfg[0]; // R10
      switching_frequency_select_o <= cfg[3:2]; // R11
      phase_clock_select_o         <= cfg[5:4]; // R12
      voltage_ramp_speed_select_o  <= cfg[7:6]; // R13
    end
  end

  chk_range_mirror: assert property (@(posedge clock_i) disable iff (reset_i)
    (normal_code_o[6] == standby_code_o[6]) && (standby_code_o[6] == sleep_code_o[6])) // R7
    else $error("range bit differs between set points");

  chk_range_host_ro: assert property (@(posedge clock_i) disable iff (reset_i)
    !range_load_i |=> (range_q == $past(range_q))) // R3
    else $error("range bit changed without configuration load");

  chk_normal_write: assert property (@(posedge clock_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i == buck_regs_pkg::OFF_NORMAL) |->
      ##2 (normal_code_o[5:0] == $past(reg_wdata_i[5:0], 2))) // R2
    else $error("normal set point not written");

  chk_standby_write: assert property (@(posedge clock_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i == buck_regs_pkg::OFF_STANDBY) |->
      ##2 (standby_code_o[5:0] == $past(reg_wdata_i[5:0], 2))) // R4
    else $error("standby set point not written");

  chk_sleep_write: assert property (@(posedge clock_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i == buck_regs_pkg::OFF_SLEEP) |->
      ##2 (sleep_code_o[5:0] == $past(reg_wdata_i[5:0], 2))) // R6
    else $error("sleep set point not written");

  chk_mode_write: assert property (@(posedge clock_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i == buck_regs_pkg::OFF_MODE) |->
      ##2 ((switching_mode_o == $past(reg_wdata_i[3:0], 2))
      && (sleep_behaviour_bit_o == $past(reg_wdata_i[5], 2)))) // R8 R9
    else $error("mode register not written");

  chk_config_write: assert property (@(posedge clock_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i == buck_regs_pkg::OFF_CONFIG) |->
      ##2 ({voltage_ramp_speed_select_o, phase_clock_select_o,
      switching_frequency_select_o, current_limit_select_o} == {$past(reg_wdata_i[7:2], 2),
      $past(reg_wdata_i[0], 2)})) // R10 R11 R12 R13
    else $error("config register not written");

  chk_unused_zero: assert property (@(posedge clock_i) disable iff (reset_i)
    reg_rvalid_o |-> (reg_rdata_o[7] == 1'b0 || $past(reg_addr_i, 2) == buck_regs_pkg::OFF_CONFIG)
      && ($past(reg_addr_i, 2) != buck_regs_pkg::OFF_MODE || reg_rdata_o[4] == 1'b0)
      && ($past(reg_addr_i, 2) != buck_regs_pkg::OFF_MODE || reg_rdata_o[6] == 1'b0)) // R15
    else $error("unused bit read back as one");

  // a read strobe is answered two edges later, and only then
  chk_read_answer: assert property (@(posedge clock_i) disable iff (reset_i)
    reg_rd_i |-> ##2 reg_rvalid_o) // R1
    else $error("read strobe not answered");

  chk_answer_cause: assert property (@(posedge clock_i) disable iff (reset_i)
    reg_rvalid_o |-> $past(reg_rd_i, 2)) // R1
    else $error("read answer without a strobe");

  chk_unmapped_read: assert property (@(posedge clock_i) disable iff (reset_i)
    (reg_rvalid_o && (($past(reg_addr_i, 2) < buck_regs_pkg::OFF_NORMAL) ||
      ($past(reg_addr_i, 2) > buck_regs_pkg::OFF_CONFIG))) |-> (reg_rdata_o == 8'h00)) // R15
    else $error("unmapped address read back nonzero");

  chk_range_readback: assert property (@(posedge clock_i) disable iff (reset_i)
    (reg_rvalid_o && ($past(reg_addr_i, 2) >= buck_regs_pkg::OFF_NORMAL) &&
      ($past(reg_addr_i, 2) <= buck_regs_pkg::OFF_SLEEP)) |->
      (reg_rdata_o[6] == normal_code_o[6])) // R5 R7
    else $error("set point range bit read back wrong");

  chk_range_load: assert property (@(posedge clock_i) disable iff (reset_i)
    range_load_i |=> (range_q == $past(range_value_i))) // R3
    else $error("range bit not loaded from configuration");

  chk_unmapped_write: assert property (@(posedge clock_i) disable iff (reset_i)
    (reg_wr_i && !hit) |=> (flat == $past(flat))) // R1
    else $error("unmapped write changed the bank");

  chk_unused_storage: assert property (@(posedge clock_i) disable iff (reset_i)
    (nrm[7:6] == 2'b00) && (stb[7:6] == 2'b00) && (slp[7:6] == 2'b00) &&
      (mde[7:6] == 2'b00) && (mde[4] == 1'b0)) // R15
    else $error("unused storage bit set");
endmodule : buck_two_control_regs

// ### verilog/buck_regs_pkg.sv
/*
  package for the second buck converter register bank: offsets, field positions, resets.
  assumes an 8-bit register access port from the device's serial control front end.
*/
package buck_regs_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] OFF_NORMAL  = 8'h35;
  localparam logic [7:0] OFF_STANDBY = 8'h36;
  localparam logic [7:0] OFF_SLEEP   = 8'h37;
  localparam logic [7:0] OFF_MODE    = 8'h38;
  localparam logic [7:0] OFF_CONFIG  = 8'h39;
  localparam logic [7:0] OFF_FIRST   = 8'h35;
  localparam int unsigned NUM_REGS   = 5;
  localparam int unsigned SETPT_MSB  = 5;
  localparam int unsigned RANGE_BIT  = 6;
  localparam int unsigned MODE_MSB   = 3;
  localparam int unsigned SLEEP_BIT  = 5;
  localparam int unsigned ILIM_BIT   = 0;
  localparam int unsigned FREQ_LSB   = 2;
  localparam int unsigned PHASE_LSB  = 4;
  localparam int unsigned RAMP_LSB   = 6;
  localparam logic [7:0] RST_NORMAL  = 8'h00;
  localparam logic [7:0] RST_STANDBY = 8'h00;
  localparam logic [7:0] RST_SLEEP   = 8'h00;
  localparam logic [7:0] RST_MODE    = 8'h00;
  localparam logic [7:0] RST_CONFIG  = 8'h00;
  localparam logic [7:0] MASK_SETPT  = 8'h3F;
  localparam logic [7:0] MASK_MODE   = 8'h2F;
  localparam logic [7:0] MASK_CONFIG = 8'hFF;
endpackage : buck_regs_pkg

// ### verilog/buck_reg_mem.sv
/*
  small register storage for the bank: five bytes, masked write, registered read data.
  assumes a single synchronous clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module buck_reg_mem #(
  parameter int unsigned DEPTH = buck_regs_pkg::NUM_REGS
) (
  // clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  reset_i,
  // write side
  input  wire logic                  wr_en_i,
  input  wire logic [2:0]            wr_idx_i,
  input  wire logic [7:0]            wr_data_i,
  input  wire logic [7:0]            wr_mask_i,
  // read side
  input  wire logic [2:0]            rd_idx_i,
  output logic      [7:0]            rd_data_o,
  // whole contents
  output logic      [DEPTH*8-1:0]    flat_o
);
  logic [7:0] mem_q [DEPTH];

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mem_q[0] <= buck_regs_pkg::RST_NORMAL;
      mem_q[1] <= buck_regs_pkg::RST_STANDBY;
      mem_q[2] <= buck_regs_pkg::RST_SLEEP;
      mem_q[3] <= buck_regs_pkg::RST_MODE;
      mem_q[4] <= buck_regs_pkg::RST_CONFIG;
      rd_data_o <= 8'h00;
    end else begin
      if (wr_en_i && (32'(wr_idx_i) < DEPTH)) begin
        mem_q[wr_idx_i] <= (mem_q[wr_idx_i] & ~wr_mask_i) | (wr_data_i & wr_mask_i);
      end
      rd_data_o <= (32'(rd_idx_i) < DEPTH) ? mem_q[rd_idx_i] : 8'h00;
    end
  end

  for (genvar g = 0; g < DEPTH; g++) begin : g_flat
    assign flat_o[g*8 +: 8] = mem_q[g];
  end
endmodule : buck_reg_mem

// ### tb/host_model.sv
/*
  host side of the register access port: byte writes and reads as one-cycle strobes.
  assumes the bank answers a read with a one-cycle valid a few edges after the strobe.
*/
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic       clock_i,
  // answer from the bank
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i,
  // requests to the bank
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o
);
  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // one byte write, lines inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    reg_wr_o    <= 1'b1;
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    @(negedge clock_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
  endtask : wr

  // one byte read, waits a bounded time for the answer
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    d = 8'hxx;
    @(negedge clock_i);
    reg_rd_o   <= 1'b1;
    reg_addr_o <= a;
    @(negedge clock_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
    for (n = 0; n < 8; n++) begin
      @(posedge clock_i);
      #1;
      if (reg_rvalid_i === 1'b1) begin
        d = reg_rdata_i;
        break;
      end
    end
  endtask : rd
endmodule : host_model

// ### tb/tb_top.sv
/*
  testbench of the buck control bank: reset values, masks, read-only range bits, fields.
  assumes the host model drives the access port at the falling clock edge.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic       clock_i = 1'b0;
  logic       reset_i = 1'b1;
  logic       range_load_i = 1'b0;
  logic       range_value_i = 1'b0;
  logic       reg_wr, reg_rd, rvalid;
  logic [7:0] addr, wdata, rdata, d;
  logic [6:0] nrm, stb, slp;
  logic [3:0] mode;
  logic       slb, ilim;
  logic [1:0] freq, phase, ramp;
  int         error_cnt = 0;
  int         samples_checked = 0;
  int         i;
  logic [7:0] adr [7] = '{8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h34, 8'h3A};
  logic [7:0] msk [7] = '{8'h3F, 8'h3F, 8'h3F, 8'h2F, 8'hFF, 8'h00, 8'h00};

  always #5 clock_i = ~clock_i;

  host_model host_model_inst (.clock_i(clock_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(addr), .reg_wdata_o(wdata));

  buck_two_control_regs buck_two_control_regs_inst (.clock_i(clock_i), .reset_i(reset_i),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .range_load_i(range_load_i),
    .range_value_i(range_value_i), .normal_code_o(nrm), .standby_code_o(stb),
    .sleep_code_o(slp), .switching_mode_o(mode), .sleep_behaviour_bit_o(slb),
    .current_limit_select_o(ilim), .switching_frequency_select_o(freq),
    .phase_clock_select_o(phase), .voltage_ramp_speed_select_o(ramp));

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #50000;
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge clock_i);
    @(negedge clock_i);
    reset_i = 1'b0;
    for (i = 0; i < 7; i++) begin
      host_model_inst.rd(adr[i], d);
      `CHK("reset value", 8'h00, d)
    end
    for (i = 0; i < 7; i++) host_model_inst.wr(adr[i], 8'hFF);
    for (i = 0; i < 7; i++) begin
      host_model_inst.rd(adr[i], d);
      `CHK("masked readback", msk[i], d)
    end
    `CHK("set point outputs", {3{7'h3F}}, {nrm, stb, slp})
    `CHK("mode outputs", 5'h1F, {mode, slb})
    `CHK("config outputs", 7'h7F, {ramp, phase, freq, ilim})
    host_model_inst.wr(8'h39, 8'h64);
    host_model_inst.wr(8'h38, 8'h1A);
    host_model_inst.rd(8'h39, d);
    `CHK("config readback", 8'h64, d)
    `CHK("config fields", 7'b01_10_01_0, {ramp, phase, freq, ilim})
    host_model_inst.rd(8'h38, d);
    `CHK("mode readback", 8'h0A, d)
    `CHK("mode fields", 5'b1010_0, {mode, slb})
    @(negedge clock_i);
    range_load_i  = 1'b1;
    range_value_i = 1'b1;
    @(negedge clock_i);
    range_load_i  = 1'b0;
    range_value_i = 1'b0;
    host_model_inst.wr(8'h35, 8'h00);
    for (i = 0; i < 3; i++) begin
      host_model_inst.rd(adr[i], d);
      `CHK("range readback", (i == 0) ? 8'h40 : 8'h7F, d)
    end
    `CHK("range outputs", {7'h40, 7'h7F, 7'h7F}, {nrm, stb, slp})
    host_model_inst.wr(8'h3A, 8'h00);
    host_model_inst.wr(8'h3E, 8'h00);
    host_model_inst.rd(8'h39, d);
    `CHK("unmapped write ignored", 8'h64, d)
    host_model_inst.rd(8'h36, d);
    `CHK("unmapped write ignored", 8'h7F, d)
    host_model_inst.rd(8'h3D, d);
    `CHK("unmapped read zero", 8'h00, d)
    final_report();
  end
endmodule : tb_top
